/* File: pkg/guard_pkg.sv */
// Package: register map, field positions and fault detail layout
// Assumes a 32-bit AHB-Lite register bus and a single core clock
package guard_pkg;

    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [5:0] OFF_FEATURE_EDX = 6'h00;
    localparam logic [5:0] OFF_GUEST_STATE = 6'h04;
    localparam logic [5:0] OFF_INT_STATUS = 6'h08;
    localparam logic [5:0] OFF_INT_MASK = 6'h0C;
    localparam logic [5:0] OFF_LAST_DETAIL = 6'h10;
    localparam logic [5:0] OFF_CTL_WORD = 6'h14;

    // ----------------------------------------
    // Feature query result bits (EDX)
    // ----------------------------------------
    localparam int FEAT_EXEC_TRAP_BIT = 17;
    localparam int FEAT_STACK_GUARD_BIT = 19;

    // ----------------------------------------
    // Guest control block word at 090h
    // ----------------------------------------
    localparam logic [11:0] CTL_WORD_OFFSET = 12'h090;
    localparam int CTL_EXEC_TRAP_BIT = 3;
    localparam int CTL_STACK_GUARD_BIT = 4;

    // ----------------------------------------
    // Guest state register fields
    // ----------------------------------------
    localparam int GST_RUNNING = 0;
    localparam int GST_EXEC_TRAP = 1;
    localparam int GST_STACK_GUARD = 2;
    localparam int GST_HOST_NXE = 3;

    // ----------------------------------------
    // Interrupt status / mask fields
    // ----------------------------------------
    localparam int INT_W = 3;
    localparam int INT_FAULT = 0;
    localparam int INT_INVALID = 1;
    localparam int INT_ENTERED = 2;
    localparam logic [INT_W-1:0] INT_MASK_RESET = 3'h0;

    // ----------------------------------------
    // Page fault error code bits in the detail word
    // ----------------------------------------
    localparam int ERR_PRESENT = 0;
    localparam int ERR_WRITE = 1;
    localparam int ERR_USER = 2;
    localparam int ERR_FETCH = 4;
    localparam int ERR_SHADOW = 6;

    localparam logic [1:0] USER_LEVEL = 2'h3;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

endpackage

/* File: design/perm_check.sv */
// Per-access nested permission verdict, registered one cycle after request
// Assumes enables are stable for the whole guest run
`timescale 1ns/1ps
module perm_check
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic req_valid,
    input wire logic req_fetch,
    input wire logic req_write,
    input wire logic req_shadow,
    input wire logic [1:0] req_level,
    input wire logic leaf_no_exec,
    input wire logic leaf_user,
    input wire logic leaf_write,
    input wire logic upper_write_all,
    input wire logic trap_en,
    input wire logic guard_en,
    input wire logic host_nxe,
    output logic rsp_valid,
    output logic rsp_fault,
    output logic [31:0] rsp_detail
);

    typedef struct packed
    {
        logic valid;
        logic fault;
        logic [31:0] detail;
    } check_state_t;

    check_state_t cur;
    check_state_t nxt;

    always_comb
    begin
        logic eff_no_exec;
        logic supervisor;
        logic stack_page;
        logic bad;
        logic [31:0] code;
        eff_no_exec = leaf_no_exec & host_nxe;
        supervisor = (req_level != guard_pkg::USER_LEVEL);
        stack_page = leaf_no_exec & ~leaf_user & upper_write_all;
        bad = 1'b0;
        code = guard_pkg::WORD_ZERO;
        nxt = cur;
        nxt.valid = req_valid;
        if (req_fetch)
        begin
            // No-execute wins at every level, stack pages included
            if (eff_no_exec)
            begin
                bad = 1'b1;
            end
            else if (trap_en && leaf_user && supervisor)
            begin
                bad = 1'b1;
            end
            // Otherwise allowed, including supervisor fetch of supervisor pages
        end
        else if (guard_en && req_shadow && supervisor)
        begin
            // Stack pages accept shadow-stack writes even when leaf is read-only
            bad = ~stack_page;
            code[guard_pkg::ERR_SHADOW] = 1'b1;
        end
        else if (req_write && !leaf_write)
        begin
            bad = 1'b1;
        end
        // Plain error code only; no bit tells trap faults from no-execute
        code[guard_pkg::ERR_PRESENT] = 1'b1;
        code[guard_pkg::ERR_WRITE] = req_write;
        code[guard_pkg::ERR_USER] = ~supervisor;
        code[guard_pkg::ERR_FETCH] = req_fetch;
        nxt.fault = req_valid & bad;
        if (req_valid && bad)
        begin
            nxt.detail = code;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= nxt;
        end
    end

    assign rsp_valid = cur.valid;
    assign rsp_fault = cur.fault;
    assign rsp_detail = cur.detail;

endmodule

/* File: design/nested_page_exec_stack_guard.sv */
// Nested page execute-trap and supervisor-stack guard checker with AHB-Lite registers
// Assumes core and walker signals are on hclk; walker supplies effective leaf bits
//
// Contract
// - Feature word reports execute-trap support in EDX bit 17.
// - Entry enables execute trap from control word bit 3 when implemented.
// - Effective no-execute forbids fetch at every privilege level.
// - Trap on: supervisor fetch from user page gives nested fault exit.
// - Trap on: fetch from supervisor executable page allowed at all levels.
// - Trap fault uses ordinary error code, no distinguishing bit.
// - Feature word reports stack-guard support in EDX bit 19.
// - Entry enables stack guard from bit 4 with nested paging and host modes.
// - Guard on with nested paging off: invalid-state exit, no guest start.
// - Host without extended addressing or no-execute: guard request silently ignored.
// - Guard enable does not depend on guest shadow-stack state.
// - Stack page: leaf no-execute, leaf supervisor, all upper levels writable.
// - Guard on: supervisor shadow access to non-stack page faults with shadow flag.
// - Shadow-stack writes to stack pages complete despite read-only leaf.
// - Fetch from stack page faults like any no-execute page.
// - Host no-execute cleared makes nested no-execute bits ignored.
`timescale 1ns/1ps
module nested_page_exec_stack_guard
#(
    parameter int ADDR_W = 32,
    parameter bit EXEC_TRAP_IMPL = 1'b1,
    parameter bit STACK_GUARD_IMPL = 1'b1
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic guest_entry_op,
    input wire logic [31:0] guest_control_word,
    input wire logic nested_paging_en,
    input wire logic ext_address_mode,
    input wire logic host_no_exec_enable,
    input wire logic guest_exit,
    input wire logic req_valid,
    input wire logic req_fetch,
    input wire logic req_write,
    input wire logic req_shadow,
    input wire logic [1:0] current_privilege_level,
    input wire logic leaf_no_exec,
    input wire logic leaf_user,
    input wire logic leaf_write,
    input wire logic upper_write_all,
    output logic entry_started,
    output logic entry_invalid,
    output logic guest_running,
    output logic rsp_valid,
    output logic nested_fault_exit,
    output logic [31:0] exit_detail_word,
    output logic irq
);

    // ----------------------------------------
    // Elaboration checks
    // ----------------------------------------
    if (ADDR_W < 6 || ADDR_W > 32)
    begin : g_addr_chk
        $error("ADDR_W must be 6 to 32");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed
    {
        logic hreadyout;
        logic [31:0] hrdata;
        logic wr_pend;
        logic [5:0] wr_off;
        logic running;
        logic trap_en;
        logic guard_en;
        logic nxe;
        logic [31:0] ctl_word;
        logic started;
        logic invalid;
        logic [guard_pkg::INT_W-1:0] int_status;
        logic [guard_pkg::INT_W-1:0] int_mask;
        logic [31:0] last_detail;
        logic irq;
    } guard_state_t;

    guard_state_t cur;
    guard_state_t nxt;

    logic chk_valid;
    logic chk_fault;
    logic [31:0] chk_detail;
    logic [31:0] feature_word;

    // ----------------------------------------
    // Feature query word
    // ----------------------------------------
    always_comb
    begin
        feature_word = guard_pkg::WORD_ZERO;
        feature_word[guard_pkg::FEAT_EXEC_TRAP_BIT] = EXEC_TRAP_IMPL;
        feature_word[guard_pkg::FEAT_STACK_GUARD_BIT] = STACK_GUARD_IMPL;
    end

    // ----------------------------------------
    // Access verdict
    // ----------------------------------------
    // Requests outside a guest run are ignored; the enables feeding the
    // checker are the ones latched at entry, never the live control word.
    perm_check u_check
    (
        .hclk(hclk),
        .hresetn(hresetn),
        .req_valid(req_valid & cur.running),
        .req_fetch(req_fetch),
        .req_write(req_write),
        .req_shadow(req_shadow),
        .req_level(current_privilege_level),
        .leaf_no_exec(leaf_no_exec),
        .leaf_user(leaf_user),
        .leaf_write(leaf_write),
        .upper_write_all(upper_write_all),
        .trap_en(cur.trap_en),
        .guard_en(cur.guard_en),
        .host_nxe(cur.nxe),
        .rsp_valid(chk_valid),
        .rsp_fault(chk_fault),
        .rsp_detail(chk_detail)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb
    begin
        logic take;
        logic [5:0] off;
        logic [guard_pkg::INT_W-1:0] evt;
        logic [guard_pkg::INT_W-1:0] clr;
        logic trap_req;
        logic guard_req;
        logic host_ok;
        take = 1'b0;
        off = 6'h00;
        evt = '0;
        clr = '0;
        trap_req = 1'b0;
        guard_req = 1'b0;
        host_ok = 1'b0;
        nxt = cur;
        nxt.started = 1'b0;
        nxt.invalid = 1'b0;
        nxt.hreadyout = 1'b1;

        // Guest entry: enables sampled once and held until exit
        if (guest_entry_op && !cur.running)
        begin
            trap_req = guest_control_word[guard_pkg::CTL_EXEC_TRAP_BIT] & EXEC_TRAP_IMPL;
            guard_req = guest_control_word[guard_pkg::CTL_STACK_GUARD_BIT] & STACK_GUARD_IMPL;
            host_ok = ext_address_mode & host_no_exec_enable;
            nxt.ctl_word = guest_control_word;
            if (guard_req && !nested_paging_en)
            begin
                nxt.invalid = 1'b1;
                evt[guard_pkg::INT_INVALID] = 1'b1;
            end
            else
            begin
                nxt.running = 1'b1;
                nxt.started = 1'b1;
                nxt.trap_en = trap_req;
                // Guest shadow-stack state plays no part here
                nxt.guard_en = guard_req & nested_paging_en & host_ok;
                nxt.nxe = host_no_exec_enable;
                evt[guard_pkg::INT_ENTERED] = 1'b1;
            end
        end
        else if (guest_exit && cur.running)
        begin
            nxt.running = 1'b0;
        end

        // A nested fault ends the run and records the detail word
        if (chk_fault)
        begin
            nxt.running = 1'b0;
            nxt.last_detail = chk_detail;
            evt[guard_pkg::INT_FAULT] = 1'b1;
        end

        // Bus data phase for a write
        nxt.wr_pend = 1'b0;
        if (cur.wr_pend)
        begin
            unique case (cur.wr_off)
                guard_pkg::OFF_INT_STATUS:
                begin
                    clr = hwdata[guard_pkg::INT_W-1:0];
                end
                guard_pkg::OFF_INT_MASK:
                begin
                    nxt.int_mask = hwdata[guard_pkg::INT_W-1:0];
                end
                default:
                begin
                    // Read-only or unmapped: write dropped, still OKAY
                end
            endcase
        end

        // Set wins over a clear landing in the same cycle
        nxt.int_status = (cur.int_status & ~clr) | evt;

        // Bus address phase
        take = hsel & htrans[1] & hready;
        off = haddr[5:0];
        if (take)
        begin
            nxt.wr_pend = hwrite;
            nxt.wr_off = off;
            nxt.hrdata = guard_pkg::WORD_ZERO;
            if (!hwrite)
            begin
                unique case (off)
                    guard_pkg::OFF_FEATURE_EDX:
                    begin
                        nxt.hrdata = feature_word;
                    end
                    guard_pkg::OFF_GUEST_STATE:
                    begin
                        nxt.hrdata[guard_pkg::GST_RUNNING] = cur.running;
                        nxt.hrdata[guard_pkg::GST_EXEC_TRAP] = cur.trap_en;
                        nxt.hrdata[guard_pkg::GST_STACK_GUARD] = cur.guard_en;
                        nxt.hrdata[guard_pkg::GST_HOST_NXE] = cur.nxe;
                    end
                    guard_pkg::OFF_INT_STATUS:
                    begin
                        nxt.hrdata[guard_pkg::INT_W-1:0] = cur.int_status;
                    end
                    guard_pkg::OFF_INT_MASK:
                    begin
                        nxt.hrdata[guard_pkg::INT_W-1:0] = cur.int_mask;
                    end
                    guard_pkg::OFF_LAST_DETAIL:
                    begin
                        nxt.hrdata = cur.last_detail;
                    end
                    guard_pkg::OFF_CTL_WORD:
                    begin
                        nxt.hrdata = cur.ctl_word;
                    end
                    default:
                    begin
                        nxt.hrdata = guard_pkg::WORD_ZERO;
                    end
                endcase
            end
        end

        // Level interrupt from the registered status and mask
        nxt.irq = |(nxt.int_status & nxt.int_mask);
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            cur <= '0;
            cur.hreadyout <= 1'b1;
            cur.int_mask <= guard_pkg::INT_MASK_RESET;
        end
        else
        begin
            cur <= nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Leaf write-permit on stack pages is left to the hypervisor
    assign hreadyout = cur.hreadyout;
    assign hrdata = cur.hrdata;
    assign hresp = 1'b0;
    assign entry_started = cur.started;
    assign entry_invalid = cur.invalid;
    assign guest_running = cur.running;
    assign rsp_valid = chk_valid;
    assign nested_fault_exit = chk_fault;
    assign exit_detail_word = chk_detail;
    assign irq = cur.irq;

endmodule

/* File: sim/guard_assertions.sv */
// Checker: entry and access verdict relations at the guard's ports
// Assumes one clock domain; bound into the top module
`timescale 1ns/1ps
module guard_chk
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic guest_entry_op,
    input wire logic [31:0] guest_control_word,
    input wire logic nested_paging_en,
    input wire logic ext_address_mode,
    input wire logic host_no_exec_enable,
    input wire logic req_valid,
    input wire logic req_fetch,
    input wire logic req_write,
    input wire logic req_shadow,
    input wire logic [1:0] current_privilege_level,
    input wire logic leaf_no_exec,
    input wire logic leaf_user,
    input wire logic upper_write_all,
    input wire logic entry_started,
    input wire logic entry_invalid,
    input wire logic guest_running,
    input wire logic rsp_valid,
    input wire logic nested_fault_exit,
    input wire logic [31:0] exit_detail_word
);
    logic trap_l;
    logic guard_l;
    logic nxe_l;
    logic take;
    logic acc;
    logic sup;
    logic stack_pg;
    logic sup_fetch;
    assign take = guest_entry_op && !guest_running;
    assign acc = req_valid && guest_running;
    assign sup = current_privilege_level != guard_pkg::USER_LEVEL;
    assign stack_pg = leaf_no_exec && !leaf_user && upper_write_all;
    assign sup_fetch = acc && req_fetch && !req_write && !req_shadow && sup;
    // Shadow copy of the enables taken at entry
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            trap_l <= 1'b0;
            guard_l <= 1'b0;
            nxe_l <= 1'b0;
        end
        else if (take)
        begin
            trap_l <= guest_control_word[3];
            guard_l <= guest_control_word[4] && nested_paging_en && ext_address_mode && host_no_exec_enable;
            nxe_l <= host_no_exec_enable;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    bus_okay_a: assert property (hreadyout && !hresp) else $error("bus slave not ready or not okay");
    rsp_timing_a: assert property (rsp_valid == $past(acc)) else $error("response not one cycle after request");
    no_exec_fetch_a: assert property (acc && req_fetch && leaf_no_exec && nxe_l |=> nested_fault_exit)
        else $error("fetch from no-execute page allowed");
    exec_trap_a: assert property (sup_fetch && !leaf_no_exec && leaf_user && trap_l
        |=> nested_fault_exit && exit_detail_word[4] && !exit_detail_word[6]) else $error("trap fault wrong");
    sup_exec_a: assert property (sup_fetch && !leaf_user && !(leaf_no_exec && nxe_l)
        |=> rsp_valid && !nested_fault_exit) else $error("supervisor page fetch refused");
    shadow_fault_a: assert property (acc && !req_fetch && req_shadow && sup && guard_l && !stack_pg
        |=> nested_fault_exit && exit_detail_word[6]) else $error("shadow access off stack page allowed");
    stack_write_a: assert property (acc && !req_fetch && req_shadow && sup && guard_l && stack_pg
        |=> rsp_valid && !nested_fault_exit) else $error("stack page shadow write refused");
    entry_invalid_a: assert property (take && guest_control_word[4] && !nested_paging_en
        |=> entry_invalid && !entry_started && !guest_running) else $error("invalid entry started");
    guard_ignored_a: assert property (take && nested_paging_en && !(ext_address_mode && host_no_exec_enable)
        |=> entry_started && !entry_invalid) else $error("guard request not ignored");
    fault_stop_a: assert property (nested_fault_exit |-> rsp_valid ##1 !guest_running) else $error("fault kept guest");
    cover property (acc ##1 nested_fault_exit);
    cover property (take ##1 entry_invalid);
    cover property (acc && req_shadow && guard_l ##1 rsp_valid && !nested_fault_exit);
endmodule
bind nested_page_exec_stack_guard guard_chk i_chk (.hclk, .hresetn, .hreadyout, .hresp, .guest_entry_op,
    .guest_control_word, .nested_paging_en, .ext_address_mode, .host_no_exec_enable, .req_valid, .req_fetch,
    .req_write, .req_shadow, .current_privilege_level, .leaf_no_exec, .leaf_user, .upper_write_all,
    .entry_started, .entry_invalid, .guest_running, .rsp_valid, .nested_fault_exit, .exit_detail_word);

/* File: sim/core_walker_model.sv */
// Core access path and nested walker model, one access at a time
// Assumes the guard answers one cycle after the request edge
`timescale 1ns/1ps
module core_walker_model
(
    input wire logic hclk,
    input wire logic rsp_valid,
    input wire logic nested_fault_exit,
    output logic req_valid,
    output logic req_fetch,
    output logic req_write,
    output logic req_shadow,
    output logic [1:0] current_privilege_level,
    output logic leaf_no_exec,
    output logic leaf_user,
    output logic leaf_write,
    output logic upper_write_all
);
    initial
    begin
        req_valid = 1'b0;
        {req_fetch, req_write, req_shadow, current_privilege_level} = 5'h0;
        {leaf_no_exec, leaf_user, leaf_write, upper_write_all} = 4'h0;
    end
    // a = {fetch, write, shadow, level[1:0], no_exec, user, leaf_write, upper_write_all}
    task automatic access(input logic [8:0] a, output logic [1:0] r);
        @(posedge hclk);
        req_valid <= 1'b1;
        {req_fetch, req_write, req_shadow, current_privilege_level} <= a[8:4];
        {leaf_no_exec, leaf_user, leaf_write, upper_write_all} <= a[3:0];
        @(posedge hclk);
        req_valid <= 1'b0;
        // Released attributes flip so a stale value cannot pass for a request
        {req_fetch, req_write, req_shadow, current_privilege_level} <= ~a[8:4];
        {leaf_no_exec, leaf_user, leaf_write, upper_write_all} <= ~a[3:0];
        @(negedge hclk);
        r = {rsp_valid, nested_fault_exit};
    endtask
endmodule

/* File: sim/testbench.sv */
// Testbench: register, entry and access sequences with expected values
// Assumes a zero-wait single slave and the core model on the access port
`timescale 1ns/1ps
module testbench;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, guest_control_word, exit_detail_word, d;
    logic [1:0] htrans, current_privilege_level, r;
    logic [2:0] hsize;
    logic guest_entry_op, nested_paging_en, ext_address_mode, host_no_exec_enable, guest_exit;
    logic req_valid, req_fetch, req_write, req_shadow, leaf_no_exec, leaf_user, leaf_write, upper_write_all;
    logic entry_started, entry_invalid, guest_running, rsp_valid, nested_fault_exit;
    int miscompares, total_checks;
    assign hready = hreadyout;
    assign hsize = 3'h2;
    nested_page_exec_stack_guard i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hreadyout, .hrdata, .hresp, .guest_entry_op, .guest_control_word, .nested_paging_en,
        .ext_address_mode, .host_no_exec_enable, .guest_exit, .req_valid, .req_fetch, .req_write, .req_shadow,
        .current_privilege_level, .leaf_no_exec, .leaf_user, .leaf_write, .upper_write_all, .entry_started,
        .entry_invalid, .guest_running, .rsp_valid, .nested_fault_exit, .exit_detail_word, .irq);
    core_walker_model i_core (.hclk, .rsp_valid, .nested_fault_exit, .req_valid, .req_fetch, .req_write,
        .req_shadow, .current_privilege_level, .leaf_no_exec, .leaf_user, .leaf_write, .upper_write_all);
    always #25 hclk = ~hclk;
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons: %0d, mismatches: %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge hclk);
        end
        if (n >= 50)
        begin
            miscompares++;
            tally_and_finish();
        end
    endtask
    task automatic ahb(input logic w, input logic [5:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {26'h0, a};
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        d = hrdata;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h0);
        check(d, e);
    endtask
    // m = {nested_paging_en, ext_address_mode, host_no_exec_enable}; e = {started, invalid}
    task automatic enter(input logic [31:0] w, input logic [2:0] m, input logic [1:0] e);
        @(posedge hclk);
        guest_exit <= 1'b1;
        @(posedge hclk);
        guest_exit <= 1'b0;
        guest_entry_op <= 1'b1;
        guest_control_word <= w;
        {nested_paging_en, ext_address_mode, host_no_exec_enable} <= m;
        @(posedge hclk);
        guest_entry_op <= 1'b0;
        @(negedge hclk);
        check({30'h0, entry_started, entry_invalid}, {30'h0, e});
    endtask
    task automatic acc(input logic [8:0] a, input logic [1:0] e);
        i_core.access(a, r);
        check({30'h0, r}, {30'h0, e});
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial
    begin
        {hclk, hresetn, hsel, hwrite, guest_entry_op, guest_exit} = 6'h0;
        {nested_paging_en, ext_address_mode, host_no_exec_enable} = 3'h0;
        {haddr, hwdata, guest_control_word, htrans} = 98'h0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        rd(guard_pkg::OFF_FEATURE_EDX, 32'h000A_0000);
        rd(guard_pkg::OFF_INT_MASK, 32'h0000_0000);
        rd(6'h18, 32'h0000_0000);
        enter(32'h0000_0008, 3'b111, 2'b10);
        rd(guard_pkg::OFF_GUEST_STATE, 32'h0000_000B);
        acc(9'b100_11_0111, 2'b10);
        acc(9'b100_00_0011, 2'b10);
        acc(9'b100_10_0111, 2'b11);
        rd(guard_pkg::OFF_LAST_DETAIL, 32'h0000_0011);
        ahb(1'b1, guard_pkg::OFF_INT_MASK, 32'h0000_0001);
        rd(guard_pkg::OFF_INT_STATUS, 32'h0000_0005);
        check({31'h0, irq}, 32'h0000_0001);
        ahb(1'b1, guard_pkg::OFF_INT_STATUS, 32'h0000_0001);
        rd(guard_pkg::OFF_INT_STATUS, 32'h0000_0004);
        check({31'h0, irq}, 32'h0000_0000);
        enter(32'h0000_0008, 3'b111, 2'b10);
        acc(9'b100_11_1011, 2'b11);
        enter(32'h0000_0008, 3'b110, 2'b10);
        acc(9'b100_00_1011, 2'b10);
        enter(32'h0000_0010, 3'b011, 2'b01);
        rd(guard_pkg::OFF_INT_STATUS, 32'h0000_0007);
        enter(32'h0000_0010, 3'b101, 2'b10);
        rd(guard_pkg::OFF_GUEST_STATE, 32'h0000_0009);
        enter(32'h0000_0010, 3'b111, 2'b10);
        rd(guard_pkg::OFF_GUEST_STATE, 32'h0000_000D);
        acc(9'b011_00_1001, 2'b10);
        acc(9'b011_00_1000, 2'b11);
        rd(guard_pkg::OFF_LAST_DETAIL, 32'h0000_0043);
        enter(32'h0000_0010, 3'b111, 2'b10);
        acc(9'b100_00_1001, 2'b11);
        acc(9'b100_00_0011, 2'b00);
        tally_and_finish();
    end
endmodule
